// *** verilog/dgp_defs.vh ***
`ifndef DGP_DEFS_VH
`define DGP_DEFS_VH

// printed offsets are register indexes; byte address is four times one
`define DGP_IDX_FIRST_DATA   32'hffff_f726
`define DGP_IDX_SECOND_DATA  32'hffff_f738
`define DGP_IDX_FIRST_LVL    32'hffff_f780
`define DGP_IDX_SECOND_LVL   32'hffff_f782

// index bits compared against awaddr/araddr[15:2]
`define DGP_IDX_BITS         14
`define DGP_IDX_MSB          13

// port and bus widths
`define DGP_PORT_W           16
`define DGP_BUS_W            32
`define DGP_ADDR_W           32
`define DGP_STRB_W           4

// data register reset value
`define DGP_DATA_RST         16'h0000

// access time: the wait lasts this many cycles; the answer follows acceptance one cycle later than this count
`define DGP_ACC_CYC          3'h4
`define DGP_CNT_W            3

// axi responses
`define DGP_RESP_OKAY        2'b00
`define DGP_RESP_SLVERR      2'b10

`endif

// *** verilog/dgp_wait.v ***
`timescale 1ns/10ps
`default_nettype none
`include "dgp_defs.vh"

module dgp_wait (
   // clock and reset
   input  wire       clk,
   input  wire       rstn,
   input  wire       sync_clr,
   // control
   input  wire       start,
   output wire       done
);

   reg [`DGP_CNT_W-1:0] cnt_q;
   reg [`DGP_CNT_W-1:0] cnt_d;

   always @* begin
      cnt_d = cnt_q;
      if (sync_clr) begin
         cnt_d = {`DGP_CNT_W{1'b0}};
      end else if (start) begin
         cnt_d = `DGP_ACC_CYC;
      end else if (cnt_q != {`DGP_CNT_W{1'b0}}) begin
         cnt_d = cnt_q - 3'h1;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= {`DGP_CNT_W{1'b0}};
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // one-cycle pulse as the count runs out
   assign done = (cnt_q == 3'h1) && !sync_clr;

endmodule
`default_nettype wire

// *** verilog/dgp_port.v ***
`timescale 1ns/10ps
`default_nettype none
`include "dgp_defs.vh"

module dgp_port (
   // clock and reset
   input  wire                   clk,
   input  wire                   rstn,
   input  wire                   hw_standby,
   // register write
   input  wire                   we,
   input  wire [1:0]             strb,
   input  wire [`DGP_PORT_W-1:0] wdata,
   // pin-function controller
   input  wire [`DGP_PORT_W-1:0] dir,
   input  wire [`DGP_PORT_W-1:0] gen_sel,
   // pins
   input  wire [`DGP_PORT_W-1:0] pin_in,
   output wire [`DGP_PORT_W-1:0] pin_out,
   output wire [`DGP_PORT_W-1:0] pin_oe,
   // register read values
   output wire [`DGP_PORT_W-1:0] data_rd,
   output wire [`DGP_PORT_W-1:0] lvl_rd
);

   reg [`DGP_PORT_W-1:0] data_q;
   reg [`DGP_PORT_W-1:0] lvl_q;

   function [`DGP_PORT_W-1:0] lane_merge;
      input [`DGP_PORT_W-1:0] old_v;
      input [`DGP_PORT_W-1:0] new_v;
      input [1:0]             lanes;
      begin
         lane_merge[7:0]  = lanes[0] ? new_v[7:0]  : old_v[7:0];
         lane_merge[15:8] = lanes[1] ? new_v[15:8] : old_v[15:8];
      end
   endfunction

   // watchdog, sleep and soft standby never reach here: data kept [RL9]
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_q <= `DGP_DATA_RST; // [RL8]
      end else if (hw_standby) begin
         data_q <= `DGP_DATA_RST; // [RL8]
      end else if (we) begin
         // stored whatever the direction or function [RL6] [RL7]
         data_q <= lane_merge(data_q, wdata, strb); // [RL1] [RL2]
      end
   end

   // no reset: the level register holds sampled pins from the first edge
   always @(posedge clk) begin
      lvl_q <= pin_in; // [RL10] [RL11] [RL12]
   end

   assign pin_out = data_q; // [RL3]
   assign pin_oe  = dir & gen_sel; // [RL3] [RL6] [RL7] [RL14]
   assign data_rd = (dir & data_q) | (~dir & lvl_q); // [RL4] [RL5] [RL15]
   assign lvl_rd  = lvl_q;

endmodule
`default_nettype wire

// *** verilog/dgp_top.v ***
// Notes on behaviour
// RL1: first port has 16-bit read/write data register
// RL2: second port has identical data register
// RL3: output pin driven from data bit directly
// RL4: direction one: read returns stored bit
// RL5: direction zero: read returns pin level
// RL6: direction zero: write stores, pin unaffected
// RL7: special function: write stores only, read stored; code returns pin level when direction is zero
// RL8: power-on and hardware standby clear; watchdog not
// RL9: data kept in software standby and sleep
// RL10: read-only pin-level register per port
// RL11: level bit is one when pin high
// RL12: level register resets to sampled pin levels
// RL13: byte and halfword access, four-five cycles
// RL14: pin function chosen by pin-function controller
// RL15: direction and function bits come as inputs
`timescale 1ns/10ps
`default_nettype none
`include "dgp_defs.vh"

module dgp_top (
   // clock and reset
   input  wire                   clk,
   input  wire                   rstn,
   // chip state
   input  wire                   wdt_reset,
   input  wire                   hw_standby,
   // axi4-lite write address
   input  wire [`DGP_ADDR_W-1:0] s_axi_awaddr,
   input  wire [2:0]             s_axi_awprot,
   input  wire                   s_axi_awvalid,
   output wire                   s_axi_awready,
   // axi4-lite write data
   input  wire [`DGP_BUS_W-1:0]  s_axi_wdata,
   input  wire [`DGP_STRB_W-1:0] s_axi_wstrb,
   input  wire                   s_axi_wvalid,
   output wire                   s_axi_wready,
   // axi4-lite write response
   output wire [1:0]             s_axi_bresp,
   output wire                   s_axi_bvalid,
   input  wire                   s_axi_bready,
   // axi4-lite read address
   input  wire [`DGP_ADDR_W-1:0] s_axi_araddr,
   input  wire [2:0]             s_axi_arprot,
   input  wire                   s_axi_arvalid,
   output wire                   s_axi_arready,
   // axi4-lite read data
   output wire [`DGP_BUS_W-1:0]  s_axi_rdata,
   output wire [1:0]             s_axi_rresp,
   output wire                   s_axi_rvalid,
   input  wire                   s_axi_rready,
   // pin-function controller, first port
   input  wire [`DGP_PORT_W-1:0] first_port_direction_bits,
   input  wire [`DGP_PORT_W-1:0] first_port_general_sel,
   // pin-function controller, second port
   input  wire [`DGP_PORT_W-1:0] second_port_direction_bits,
   input  wire [`DGP_PORT_W-1:0] second_port_general_sel,
   // first port pins
   input  wire [`DGP_PORT_W-1:0] first_pin_in,
   output wire [`DGP_PORT_W-1:0] first_pin_out,
   output wire [`DGP_PORT_W-1:0] first_pin_oe,
   // second port pins
   input  wire [`DGP_PORT_W-1:0] second_pin_in,
   output wire [`DGP_PORT_W-1:0] second_pin_out,
   output wire [`DGP_PORT_W-1:0] second_pin_oe
);

   localparam [4:0] ST_IDLE  = 5'b00001;
   localparam [4:0] ST_WWAIT = 5'b00010;
   localparam [4:0] ST_BRESP = 5'b00100;
   localparam [4:0] ST_RWAIT = 5'b01000;
   localparam [4:0] ST_RRESP = 5'b10000;

   reg [4:0]             st_q;
   reg [4:0]             st_d;
   reg                   aw_got_q;
   reg                   w_got_q;
   reg [`DGP_IDX_MSB:0]  waddr_q;
   reg [`DGP_PORT_W-1:0] wdata_q;
   reg [1:0]             wstrb_q;
   reg [`DGP_IDX_MSB:0]  raddr_q;
   reg [1:0]             bresp_q;
   reg [`DGP_BUS_W-1:0]  rdata_q;
   reg [1:0]             rresp_q;

   wire                   aw_hs;
   wire                   w_hs;
   wire                   ar_hs;
   wire                   b_hs;
   wire                   r_hs;
   wire                   wr_ready;
   wire                   wait_start;
   wire                   wait_done;
   wire                   first_we;
   wire                   second_we;
   wire                   wr_hit;
   wire                   rd_hit;
   wire [`DGP_PORT_W-1:0] first_data_rd;
   wire [`DGP_PORT_W-1:0] first_lvl_rd;
   wire [`DGP_PORT_W-1:0] second_data_rd;
   wire [`DGP_PORT_W-1:0] second_lvl_rd;

   reg [`DGP_PORT_W-1:0]  rd_val;

   // compares a word index taken from the bus address with a register
   function idx_hit;
      input [`DGP_IDX_MSB:0] idx;
      input [31:0]           reg_idx;
      begin
         idx_hit = (idx == reg_idx[`DGP_IDX_MSB:0]);
      end
   endfunction

   // -------- channel handshakes

   // write takes priority: a read is only accepted with no write pending
   assign s_axi_awready = st_q[0] && !aw_got_q;
   assign s_axi_wready  = st_q[0] && !w_got_q;
   assign s_axi_arready = st_q[0] && !aw_got_q && !w_got_q &&
                          !s_axi_awvalid && !s_axi_wvalid;

   assign aw_hs = s_axi_awvalid && s_axi_awready;
   assign w_hs  = s_axi_wvalid && s_axi_wready;
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   assign b_hs  = s_axi_bvalid && s_axi_bready;
   assign r_hs  = s_axi_rvalid && s_axi_rready;

   // both halves of a write held, whichever came first
   assign wr_ready = st_q[0] && (aw_got_q || aw_hs) && (w_got_q || w_hs);

   // -------- write address and data capture

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         aw_got_q <= 1'b0;
         waddr_q  <= {`DGP_IDX_BITS{1'b0}};
      end else begin
         // address kept even when taken with its data, for the response
         aw_got_q <= !(wdt_reset || wr_ready) && (aw_got_q || aw_hs);
         if (aw_hs) begin
            waddr_q <= s_axi_awaddr[`DGP_IDX_MSB+2:2];
         end
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         w_got_q <= 1'b0;
         wdata_q <= `DGP_DATA_RST;
         wstrb_q <= 2'b00;
      end else if (wdt_reset || wr_ready) begin
         w_got_q <= 1'b0;
      end else if (w_hs) begin
         w_got_q <= 1'b1;
         wdata_q <= s_axi_wdata[`DGP_PORT_W-1:0];
         wstrb_q <= s_axi_wstrb[1:0];
      end
   end

   // -------- read address capture

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         raddr_q <= {`DGP_IDX_BITS{1'b0}};
      end else if (ar_hs) begin
         raddr_q <= s_axi_araddr[`DGP_IDX_MSB+2:2];
      end
   end

   // -------- sequencer

   always @* begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (wr_ready) begin
               st_d = ST_WWAIT;
            end else if (ar_hs) begin
               st_d = ST_RWAIT;
            end
         end
         ST_WWAIT: begin
            if (wait_done) begin
               st_d = ST_BRESP;
            end
         end
         ST_BRESP: begin
            if (b_hs) begin
               st_d = ST_IDLE;
            end
         end
         ST_RWAIT: begin
            if (wait_done) begin
               st_d = ST_RRESP;
            end
         end
         ST_RRESP: begin
            if (r_hs) begin
               st_d = ST_IDLE;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= ST_IDLE;
      end else if (wdt_reset) begin
         // watchdog restarts the bus side only; port data stay
         st_q <= ST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // the fixed wait makes every access the same length, any size
   assign wait_start = (st_q[0] && (wr_ready || ar_hs)); // [RL13]

   dgp_wait u_wait (
      .clk      (clk),
      .rstn     (rstn),
      .sync_clr (wdt_reset),
      .start    (wait_start),
      .done     (wait_done)
   );

   // -------- write decode

   // writes land as the wait begins so pins follow at once
   assign first_we  = wr_ready && !wdt_reset &&
                      idx_hit(aw_got_q ? waddr_q :
                              s_axi_awaddr[`DGP_IDX_MSB+2:2],
                              `DGP_IDX_FIRST_DATA);
   assign second_we = wr_ready && !wdt_reset &&
                      idx_hit(aw_got_q ? waddr_q :
                              s_axi_awaddr[`DGP_IDX_MSB+2:2],
                              `DGP_IDX_SECOND_DATA);

   // level registers accept a write silently
   assign wr_hit = idx_hit(waddr_q, `DGP_IDX_FIRST_DATA) ||
                   idx_hit(waddr_q, `DGP_IDX_SECOND_DATA) ||
                   idx_hit(waddr_q, `DGP_IDX_FIRST_LVL) ||
                   idx_hit(waddr_q, `DGP_IDX_SECOND_LVL); // [RL10]

   // -------- ports

   dgp_port u_first (
      .clk        (clk),
      .rstn       (rstn),
      .hw_standby (hw_standby),
      .we         (first_we),
      .strb       (w_got_q ? wstrb_q : s_axi_wstrb[1:0]), // [RL13]
      .wdata      (w_got_q ? wdata_q : s_axi_wdata[`DGP_PORT_W-1:0]),
      .dir        (first_port_direction_bits),
      .gen_sel    (first_port_general_sel),
      .pin_in     (first_pin_in),
      .pin_out    (first_pin_out),
      .pin_oe     (first_pin_oe),
      .data_rd    (first_data_rd),
      .lvl_rd     (first_lvl_rd)
   );

   dgp_port u_second (
      .clk        (clk),
      .rstn       (rstn),
      .hw_standby (hw_standby),
      .we         (second_we),
      .strb       (w_got_q ? wstrb_q : s_axi_wstrb[1:0]), // [RL13]
      .wdata      (w_got_q ? wdata_q : s_axi_wdata[`DGP_PORT_W-1:0]),
      .dir        (second_port_direction_bits),
      .gen_sel    (second_port_general_sel),
      .pin_in     (second_pin_in),
      .pin_out    (second_pin_out),
      .pin_oe     (second_pin_oe),
      .data_rd    (second_data_rd),
      .lvl_rd     (second_lvl_rd)
   );

   // -------- read mux

   assign rd_hit = idx_hit(raddr_q, `DGP_IDX_FIRST_DATA) ||
                   idx_hit(raddr_q, `DGP_IDX_SECOND_DATA) ||
                   idx_hit(raddr_q, `DGP_IDX_FIRST_LVL) ||
                   idx_hit(raddr_q, `DGP_IDX_SECOND_LVL);

   always @* begin
      rd_val = {`DGP_PORT_W{1'b0}};
      if (idx_hit(raddr_q, `DGP_IDX_FIRST_DATA)) begin
         rd_val = first_data_rd; // [RL4] [RL5]
      end else if (idx_hit(raddr_q, `DGP_IDX_SECOND_DATA)) begin
         rd_val = second_data_rd; // [RL4] [RL5]
      end else if (idx_hit(raddr_q, `DGP_IDX_FIRST_LVL)) begin
         rd_val = first_lvl_rd; // [RL11]
      end else if (idx_hit(raddr_q, `DGP_IDX_SECOND_LVL)) begin
         rd_val = second_lvl_rd; // [RL11]
      end
   end

   // -------- responses

   // sampled at the end of the wait so the read shows fresh pins
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= {`DGP_BUS_W{1'b0}};
         rresp_q <= `DGP_RESP_OKAY;
      end else if (st_q[3] && wait_done) begin
         rdata_q <= {{(`DGP_BUS_W-`DGP_PORT_W){1'b0}}, rd_val};
         rresp_q <= rd_hit ? `DGP_RESP_OKAY : `DGP_RESP_SLVERR;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bresp_q <= `DGP_RESP_OKAY;
      end else if (st_q[1] && wait_done) begin
         bresp_q <= wr_hit ? `DGP_RESP_OKAY : `DGP_RESP_SLVERR;
      end
   end

   assign s_axi_bvalid = st_q[2];
   assign s_axi_bresp  = bresp_q;
   assign s_axi_rvalid = st_q[4];
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

endmodule
`default_nettype wire

// *** sim/dgp_props.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dgp_defs.vh"

module dgp_props (
   // clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        wdt_reset,
   input wire logic        hw_standby,
   // bus
   input wire logic [31:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   // function select and pins
   input wire logic [15:0] first_port_direction_bits,
   input wire logic [15:0] first_port_general_sel,
   input wire logic [15:0] second_port_direction_bits,
   input wire logic [15:0] second_port_general_sel,
   input wire logic [15:0] first_pin_out,
   input wire logic [15:0] first_pin_oe,
   input wire logic [15:0] second_pin_out,
   input wire logic [15:0] second_pin_oe
);
   localparam logic [31:0] A0 = `DGP_IDX_FIRST_DATA << 2;
   logic wr_go;
   logic rd_go;
   assign wr_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
   assign rd_go = s_axi_arvalid & s_axi_arready;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence wr_resp;
      !s_axi_bvalid [*4] ##1 s_axi_bvalid;
   endsequence
   sequence rd_resp;
      !s_axi_rvalid [*4] ##1 s_axi_rvalid;
   endsequence

   AST_WR_LAT: assert property (wr_go |-> ##1 wr_resp)
      else $error("write answer not on the fifth edge after acceptance");
   AST_RD_LAT: assert property (rd_go |-> ##1 rd_resp)
      else $error("read answer not on the fifth edge after acceptance");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before handshake");
   AST_R_HI: assert property (s_axi_rvalid |->
      s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   AST_OE_A: assert property (first_pin_oe ==
      (first_port_direction_bits & first_port_general_sel))
      else $error("first port drive enable wrong");
   AST_OE_B: assert property (second_pin_oe ==
      (second_port_direction_bits & second_port_general_sel))
      else $error("second port drive enable wrong");
   AST_WR_OUT: assert property (wr_go && !hw_standby && !wdt_reset &&
      s_axi_awaddr[15:2] == A0[15:2] && s_axi_wstrb[1:0] == 2'b11
      |=> first_pin_out == $past(s_axi_wdata[15:0]))
      else $error("written value not on first port outputs");
   AST_STBY: assert property (hw_standby |=>
      first_pin_out == 16'h0000 && second_pin_out == 16'h0000)
      else $error("standby did not clear data");
   AST_HOLD: assert property (!wr_go && !hw_standby |=>
      $stable(first_pin_out) && $stable(second_pin_out))
      else $error("data changed without a write");
endmodule

bind dgp_top dgp_props i_props (
   .clk, .rstn, .wdt_reset, .hw_standby, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .first_port_direction_bits,
   .first_port_general_sel, .second_port_direction_bits,
   .second_port_general_sel, .first_pin_out, .first_pin_oe,
   .second_pin_out, .second_pin_oe
);
`default_nettype wire

// *** sim/dgp_pin_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module dgp_pin_model (
   // device side
   input  wire logic [15:0] pin_out,
   input  wire logic [15:0] pin_oe,
   // outside world
   input  wire logic [15:0] ext_lvl,
   output logic      [15:0] pin_lvl
);
   // a driven pin shows the device value, an undriven one the outside level
   assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire

// *** sim/dual_gpio_port_data_pin_regs_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dgp_defs.vh"

module dual_gpio_port_data_pin_regs_tb_top;
   localparam logic [31:0] AD[4] = '{`DGP_IDX_FIRST_DATA << 2,
      `DGP_IDX_SECOND_DATA << 2, `DGP_IDX_FIRST_LVL << 2,
      `DGP_IDX_SECOND_LVL << 2};
   logic        clk, rstn, wdt_reset, hw_standby;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, got;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, gresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [15:0] dr[2], gs[2], ex[2], lv[2], po[2], oe[2], dq[2];
   int          miscompares, checked;

   dgp_top i_dut (
      .clk, .rstn, .wdt_reset, .hw_standby, .s_axi_awaddr,
      .s_axi_awprot(3'b000), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'b000),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready,
      .first_port_direction_bits(dr[0]), .first_port_general_sel(gs[0]),
      .second_port_direction_bits(dr[1]), .second_port_general_sel(gs[1]),
      .first_pin_in(lv[0]), .first_pin_out(po[0]), .first_pin_oe(oe[0]),
      .second_pin_in(lv[1]), .second_pin_out(po[1]), .second_pin_oe(oe[1])
   );
   dgp_pin_model i_pins_a (.pin_out(po[0]), .pin_oe(oe[0]),
      .ext_lvl(ex[0]), .pin_lvl(lv[0]));
   dgp_pin_model i_pins_b (.pin_out(po[1]), .pin_oe(oe[1]),
      .ext_lvl(ex[1]), .pin_lvl(lv[1]));

   always #2.5 clk = ~clk;

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // one write or read; valids drop only at the edge that takes them
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [15:0] d, input logic [1:0] s);
      int n;
      @(posedge clk);
      if (w) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= {16'h0000, d};
         s_axi_wstrb <= {2'b00, s};
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
      end
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_bvalid || s_axi_rvalid) break;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      gresp = w ? s_axi_bresp : s_axi_rresp;
      got = s_axi_rdata;
      if (n == 40) begin
         miscompares++;
         $display("unexpected answer at %h: expected valid seen none", a);
         wrap_up();
      end
   endtask

   // mode 0 random, 1 general output, 2 special output, 3 input
   task automatic setp(input int p, input int m);
      @(posedge clk);
      dr[p] <= m == 0 ? 16'($urandom) : m == 3 ? 16'h0000 : 16'hffff;
      gs[p] <= m == 1 ? 16'hffff : m == 2 ? 16'h0000 : 16'($urandom);
      ex[p] <= 16'($urandom);
   endtask

   function automatic logic [15:0] lvl_of(int p);
      return (dr[p] & gs[p] & dq[p]) | (~(dr[p] & gs[p]) & ex[p]);
   endfunction
   function automatic logic [15:0] rd_of(int p);
      return (dr[p] & dq[p]) | (~dr[p] & ex[p]);
   endfunction

   initial begin
      int k, p;
      logic [15:0] d;
      logic [1:0] s;
      clk = 0; rstn = 0; wdt_reset = 0; hw_standby = 0;
      s_axi_awaddr = 0; s_axi_wdata = 0; s_axi_wstrb = 0; s_axi_araddr = 0;
      s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0;
      s_axi_arvalid = 0; s_axi_rready = 0;
      dr = '{2{16'h0000}}; gs = dr; ex = dr; dq = dr;
      k = $urandom(32'h99d5);
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      for (p = 0; p < 2; p++) begin
         setp(p, 2);
         bus(0, AD[p], 16'h0000, 2'b00);
         chk("data after reset", 0, got);
         bus(0, AD[p + 2], 16'h0000, 2'b00);
         chk("level after reset", lvl_of(p), got);
      end
      $display("reset test done");
      for (k = 0; k < 32; k++) begin
         p = $urandom_range(1, 0);
         setp(p, k % 4);
         d = 16'($urandom);
         s = 2'($urandom_range(3, 1));
         bus(1, AD[p], d, s);
         chk("write resp", `DGP_RESP_OKAY, gresp);
         dq[p] = {s[1] ? d[15:8] : dq[p][15:8], s[0] ? d[7:0] : dq[p][7:0]};
         chk("pin out", dq[p], po[p]);
         chk("pin level", lvl_of(p), lv[p]);
         bus(0, AD[p], 16'h0000, 2'b00);
         chk("data read", rd_of(p), got);
         bus(0, AD[p + 2], 16'h0000, 2'b00);
         chk("level read", lvl_of(p), got);
      end
      $display("random access test done");
      bus(1, AD[3], ~lv[1], 2'b11);
      chk("level write resp", `DGP_RESP_OKAY, gresp);
      bus(0, AD[3], 16'h0000, 2'b00);
      chk("level after write", lvl_of(1), got);
      bus(1, 32'h0000_0010, 16'h5a5a, 2'b11);
      chk("unmapped write", `DGP_RESP_SLVERR, gresp);
      bus(0, 32'h0000_0010, 16'h0000, 2'b00);
      chk("unmapped read resp", `DGP_RESP_SLVERR, gresp);
      chk("unmapped read data", 0, got);
      $display("refusal test done");
      setp(0, 1);
      bus(1, AD[0], 16'ha5c3, 2'b11);
      dq[0] = 16'ha5c3;
      chk("pin out before watchdog", dq[0], po[0]);
      @(posedge clk);
      wdt_reset <= 1'b1;
      @(posedge clk);
      wdt_reset <= 1'b0;
      bus(0, AD[0], 16'h0000, 2'b00);
      chk("data after watchdog", 16'ha5c3, got);
      @(posedge clk);
      hw_standby <= 1'b1;
      repeat (2) @(posedge clk);
      hw_standby <= 1'b0;
      bus(0, AD[0], 16'h0000, 2'b00);
      chk("data after standby", 0, got);
      setp(1, 1);
      bus(1, AD[1], 16'h3c3c, 2'b11);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      bus(0, AD[1], 16'h0000, 2'b00);
      chk("data after second reset", 0, got);
      $display("reset source test done");
      wrap_up();
   end
endmodule
`default_nettype wire
